// File: rtl/scope_trigger_acquisition.sv
// scope capture unit: trigger, gating, hysteresis, segments, streaming, registers
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "scope_cfg.svh"
module scope_trigger_acquisition
    import scope_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic haddr_sel,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic option_installed,
    input wire logic trig_in3,
    input wire logic trig_in4,
    input wire logic [15:0] src_bus [0:255],
    input wire logic signed [15:0] capture_sample,
    output logic [15:0] mem_addr,
    output logic signed [15:0] mem_data,
    output logic mem_we,
    output logic shot_done,
    output logic signed [15:0] stream0_data,
    output logic stream0_valid,
    output logic signed [15:0] stream1_data,
    output logic signed [15:0] stream1_data_unused,
    output logic stream1_valid,
    output logic irq
);
    typedef struct packed
    {
        logic [8:0] ctrl;
        logic [15:0] seg_num;
        logic [4:0] rate;
        logic [1:0] gate_src;
        logic signed [15:0] level;
        logic [15:0] hyst_v;
        logic [15:0] hyst_f;
        logic [15:0] span;
        logic [7:0] src0;
        logic [7:0] src1;
        logic [15:0] bot0;
        logic [15:0] top0;
        logic [15:0] bot1;
        logic [15:0] top1;
        logic [15:0] ofs0;
        logic [15:0] ofs1;
        logic [2:0] irq_st;
        logic [2:0] irq_en;
        logic [11:0] a_addr;
        logic a_wr;
        logic a_rd;
        logic [31:0] rdata;
        acq_state_t st;
        logic [15:0] seg_size;
        logic [15:0] seg_idx;
        logic [15:0] wptr;
        logic [15:0] waddr;
        logic [15:0] rate_cnt;
        logic signed [15:0] prev;
        logic [15:0] dat;
        logic we;
        logic done;
    } top_st_t;
    top_st_t s_reg;
    top_st_t s_next;

    scope_chan_if ch0 ();
    scope_chan_if ch1 ();

    // valid source codes: 0..3 and 8..11 always, the other listed codes only with the option
    function automatic logic src_valid(input logic [7:0] code, input logic opt);
        logic basic;
        basic = code <= 8'd3 || code == 8'd8 || code == 8'd9 || code == 8'd10
            || code == 8'd11;
        src_valid = basic
            || (opt && ((code >= 8'd4 && code <= 8'd7)
            || (code >= 8'd16 && code <= 8'd23) || (code >= 8'd32 && code <= 8'd39)
            || (code >= 8'd48 && code <= 8'd55) || (code >= 8'd64 && code <= 8'd71)
            || (code >= 8'd80 && code <= 8'd83) || code == 8'd96 || code == 8'd97
            || code == 8'd112 || code == 8'd113 || (code >= 8'd144 && code <= 8'd147)
            || (code >= 8'd176 && code <= 8'd179) || (code >= 8'd192 && code <= 8'd195)
            || (code >= 8'd208 && code <= 8'd211)));
    endfunction

    // rearm distance in counts; fraction is 8.8 of span, wide product not clamped
    function automatic logic [31:0] hyst_cnt(input logic kind, input logic [15:0] v,
        input logic [15:0] f, input logic [15:0] sp);
        logic [31:0] p;
        p = 32'(f) * 32'(sp);
        hyst_cnt = kind ? {8'd0, p[31:8]} : {16'd0, v};
    endfunction

    logic signed [15:0] trig_sig;
    logic rise;
    logic fall;
    logic cond;
    logic gate_ok;
    logic [31:0] hyst;
    logic rearmed;
    logic [1:0] edge_c;
    logic [15:0] rate_div;
    logic tick;

    assign edge_c = s_reg.ctrl[`CTRL_EDGE_HI:`CTRL_EDGE_LO];
    assign trig_sig = capture_sample;
    assign rise = s_reg.prev < s_reg.level && trig_sig >= s_reg.level;
    assign fall = s_reg.prev >= s_reg.level && trig_sig < s_reg.level;
    // edge choice decides which crossing counts
    assign cond = (edge_c[0] && rise) || (edge_c[1] && fall);
    // gating only when the option is present
    assign gate_ok = !(s_reg.ctrl[`CTRL_GATE_ON] && option_installed)
        || (s_reg.gate_src == 2'd0 && trig_in3) || (s_reg.gate_src == 2'd1 && !trig_in3)
        || (s_reg.gate_src == 2'd2 && trig_in4) || (s_reg.gate_src == 2'd3 && !trig_in4);
    assign hyst = hyst_cnt(s_reg.ctrl[`CTRL_KIND], s_reg.hyst_v, s_reg.hyst_f, s_reg.span);
    // rearm needs the signal back beyond level minus/plus distance, per edge direction
    assign rearmed = hyst == 32'd0
        || (edge_c[0] && 32'(signed'(s_reg.level) - signed'(trig_sig)) >= hyst)
        || (edge_c[1] && 32'(signed'(trig_sig) - signed'(s_reg.level)) >= hyst);
    assign rate_div = 16'd1 << (s_reg.rate - `RATE_MIN);
    assign tick = s_reg.rate_cnt == 16'd0;

    // register bus, acquisition state machine and stream rate counter
    always_comb
    begin
        logic [31:0] rd;
        logic [15:0] segs;
        rd = 32'd0;
        segs = 16'd1;
        s_next = s_reg;
        s_next.we = 1'b0;
        s_next.done = 1'b0;
        s_next.prev = trig_sig;
        s_next.rate_cnt = tick ? rate_div - 16'd1 : s_reg.rate_cnt - 16'd1;
        // data phase of a write
        if (s_reg.a_wr)
        begin
            case (s_reg.a_addr)
                `OFF_CTRL: s_next.ctrl = hwdata[8:0];
                `OFF_SEG_NUM:
                    if (hwdata[31:16] == 16'd0 && hwdata[15:0] != 16'd0
                        && hwdata[15:0] <= `SEG_MAX)
                        s_next.seg_num = hwdata[15:0];
                `OFF_RATE:
                    if (hwdata[31:5] == 27'd0 && hwdata[4:0] >= `RATE_MIN
                        && hwdata[4:0] <= `RATE_MAX)
                        s_next.rate = hwdata[4:0];
                // codes above 3 would alias onto a legal input if only the low bits were kept
                `OFF_GATE_SRC:
                    if (hwdata[31:2] == 30'd0)
                        s_next.gate_src = hwdata[1:0];
                `OFF_LEVEL: s_next.level = hwdata[15:0];
                `OFF_HYST_V: s_next.hyst_v = hwdata[15:0];
                `OFF_HYST_F: s_next.hyst_f = hwdata[15:0];
                `OFF_SPAN: s_next.span = hwdata[15:0];
                `OFF_SRC0:
                    if (hwdata[31:8] == 24'd0 && src_valid(hwdata[7:0], option_installed))
                        s_next.src0 = hwdata[7:0];
                `OFF_SRC1:
                    if (hwdata[31:8] == 24'd0 && src_valid(hwdata[7:0], option_installed))
                        s_next.src1 = hwdata[7:0];
                `OFF_BOT0: s_next.bot0 = hwdata[15:0];
                `OFF_TOP0: s_next.top0 = hwdata[15:0];
                `OFF_BOT1: s_next.bot1 = hwdata[15:0];
                `OFF_TOP1: s_next.top1 = hwdata[15:0];
                `OFF_OFS0: s_next.ofs0 = hwdata[15:0];
                `OFF_OFS1: s_next.ofs1 = hwdata[15:0];
                `OFF_IRQ_EN: s_next.irq_en = hwdata[2:0];
                `OFF_IRQ_CLR: s_next.irq_st = s_reg.irq_st & ~hwdata[2:0];
                default: ;
            endcase
        end
        // address phase; reads answer one cycle later from a register
        s_next.a_wr = hsel && hready && htrans[1] && hwrite;
        s_next.a_rd = hsel && hready && htrans[1] && !hwrite;
        if (hsel && hready && htrans[1])
            s_next.a_addr = haddr[11:0];
        if (s_next.a_rd)
        begin
            case (haddr[11:0])
                `OFF_CTRL: rd = {23'd0, s_reg.ctrl};
                `OFF_SEG_NUM: rd = {16'd0, s_reg.seg_num};
                `OFF_RATE: rd = {27'd0, s_reg.rate};
                `OFF_GATE_SRC: rd = {30'd0, s_reg.gate_src};
                `OFF_LEVEL: rd = {16'd0, s_reg.level};
                `OFF_HYST_V: rd = {16'd0, s_reg.hyst_v};
                `OFF_HYST_F: rd = {16'd0, s_reg.hyst_f};
                `OFF_SPAN: rd = {16'd0, s_reg.span};
                `OFF_SRC0: rd = {24'd0, s_reg.src0};
                `OFF_SRC1: rd = {24'd0, s_reg.src1};
                `OFF_BOT0: rd = {16'd0, s_reg.bot0};
                `OFF_TOP0: rd = {16'd0, s_reg.top0};
                `OFF_BOT1: rd = {16'd0, s_reg.bot1};
                `OFF_TOP1: rd = {16'd0, s_reg.top1};
                `OFF_OFS0: rd = {16'd0, s_reg.ofs0};
                `OFF_OFS1: rd = {16'd0, s_reg.ofs1};
                `OFF_STATUS: rd = {27'd0, s_reg.st, cond};
                `OFF_IRQ_STAT: rd = {29'd0, s_reg.irq_st};
                `OFF_IRQ_EN: rd = {29'd0, s_reg.irq_en};
                `OFF_SEG_SIZE: rd = {16'd0, s_reg.seg_size};
                default: rd = 32'd0;
            endcase
            s_next.rdata = rd;
        end
        // shot size follows segment count, whole memory when not segmented
        if (s_reg.ctrl[`CTRL_SEG_ON] && option_installed)
            segs = s_reg.seg_num;
        s_next.seg_size = `MEM_WORDS / segs;
        // acquisition sequence
        case (s_reg.st)
            ARMED:
                if (cond && gate_ok)
                begin
                    s_next.st = RECORD;
                    s_next.irq_st[`IRQ_TRIG] = 1'b1;
                end
            RECORD:
            begin
                s_next.we = 1'b1;
                s_next.dat = trig_sig;
                s_next.waddr = s_reg.wptr; // write lands on the word before the advance
                s_next.wptr = s_reg.wptr + 16'd1;
                if (s_reg.wptr + 16'd1 - s_reg.seg_idx * s_reg.seg_size >= s_reg.seg_size)
                begin
                    s_next.irq_st[`IRQ_SHOT] = 1'b1;
                    if (s_reg.seg_idx + 16'd1 >= segs)
                    begin
                        s_next.done = 1'b1;
                        s_next.irq_st[`IRQ_DONE] = 1'b1;
                        s_next.seg_idx = 16'd0;
                        s_next.wptr = 16'd0;
                        s_next.st = REARM;
                    end
                    else
                    begin
                        s_next.seg_idx = s_reg.seg_idx + 16'd1;
                        s_next.st = GAP;
                    end
                end
            end
            GAP: s_next.st = REARM;
            REARM:
                if (rearmed)
                    s_next.st = ARMED;
            default: s_next.st = ARMED;
        endcase
        // later hardware set wins over the software clear
        if (s_reg.a_wr && s_reg.a_addr == `OFF_IRQ_CLR)
            s_next.irq_st = s_next.irq_st | (s_reg.irq_st & ~hwdata[2:0]);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.rate <= `RATE_RESET;
            s_reg.seg_num <= 16'd1;
            s_reg.seg_size <= `MEM_WORDS;
            s_reg.st <= ARMED;
        end
        else if (clk_en)
            s_reg <= s_next;
    end

    // channel hookup: sources taken straight from the registers, streaming gated by the option
    assign ch0.src = s_reg.src0;
    assign ch0.avg = !s_reg.ctrl[`CTRL_AVG0];
    assign ch0.strm_on = s_reg.ctrl[`CTRL_STRM0] && option_installed;
    assign ch0.tick = tick;
    assign ch0.sample = src_bus[s_reg.src0];
    assign ch1.src = s_reg.src1;
    assign ch1.avg = !s_reg.ctrl[`CTRL_AVG1];
    assign ch1.strm_on = s_reg.ctrl[`CTRL_STRM1] && option_installed;
    assign ch1.tick = tick;
    assign ch1.sample = src_bus[s_reg.src1];

    scope_chan u_ch0 (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .c(ch0));
    scope_chan u_ch1 (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .c(ch1));

    assign hrdata = s_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mem_addr = s_reg.waddr;
    assign mem_data = s_reg.dat;
    assign mem_we = s_reg.we;
    assign shot_done = s_reg.done;
    assign stream0_data = ch0.out_data;
    assign stream0_valid = ch0.out_valid;
    assign stream1_data = ch1.out_data;
    assign stream1_data_unused = 16'sd0;
    assign stream1_valid = ch1.out_valid;
    assign irq = |(s_reg.irq_st & s_reg.irq_en);
endmodule

// File: rtl/scope_cfg.svh
// constants for the scope capture unit: offsets, fields, resets, timing
`ifndef SCOPE_CFG_SVH
`define SCOPE_CFG_SVH
`define OFF_CTRL 12'h000
`define OFF_SEG_NUM 12'h004
`define OFF_RATE 12'h008
`define OFF_GATE_SRC 12'h00c
`define OFF_LEVEL 12'h010
`define OFF_HYST_V 12'h014
`define OFF_HYST_F 12'h018
`define OFF_SPAN 12'h01c
`define OFF_SRC0 12'h020
`define OFF_SRC1 12'h024
`define OFF_BOT0 12'h028
`define OFF_TOP0 12'h02c
`define OFF_BOT1 12'h030
`define OFF_TOP1 12'h034
`define OFF_OFS0 12'h038
`define OFF_OFS1 12'h03c
`define OFF_STATUS 12'h040
`define OFF_IRQ_STAT 12'h044
`define OFF_IRQ_CLR 12'h048
`define OFF_IRQ_EN 12'h04c
`define OFF_SEG_SIZE 12'h050
`define CTRL_SEG_ON 0
`define CTRL_GATE_ON 1
`define CTRL_KIND 2
`define CTRL_AVG0 3
`define CTRL_AVG1 4
`define CTRL_STRM0 5
`define CTRL_STRM1 6
`define CTRL_EDGE_LO 7
`define CTRL_EDGE_HI 8
`define RATE_MIN 5'd6
`define RATE_MAX 5'd16
`define RATE_RESET 5'd16
`define SRC_RESET 8'h00
`define MEM_WORDS 16'd4096
`define SEG_MAX 16'd256
`define DEAD_CYCLES 4'd1
`define IRQ_TRIG 0
`define IRQ_SHOT 1
`define IRQ_DONE 2
`endif

// File: rtl/scope_pkg.sv
// types shared by the scope capture unit
package scope_pkg;
    typedef enum logic [3:0]
    {
        ARMED = 4'b0001,
        RECORD = 4'b0010,
        REARM = 4'b0100,
        GAP = 4'b1000
    } acq_state_t;
    typedef logic signed [15:0] sample_t;
endpackage

// File: rtl/scope_chan_if.sv
// per channel configuration carried from the top to the channel datapath
`timescale 1ns/100ps
interface scope_chan_if;
    logic [7:0] src;
    logic avg;
    logic strm_on;
    logic tick;
    logic signed [15:0] sample;
    logic signed [15:0] out_data;
    logic out_valid;
    modport top (output src, avg, strm_on, tick, sample, input out_data, out_valid);
    modport chan (input src, avg, strm_on, tick, sample, output out_data, out_valid);
endinterface

// File: rtl/scope_chan.sv
// one channel: averaging or decimation and streaming at the selected rate
`timescale 1ns/100ps
module scope_chan
    import scope_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    scope_chan_if.chan c
);
    typedef struct packed
    {
        logic signed [31:0] acc;
        logic signed [15:0] pick;
        logic [15:0] cnt;
        logic signed [15:0] out;
        logic vld;
    } chan_st_t;
    chan_st_t s_reg;
    chan_st_t s_next;

    // accumulate between rate ticks; average divides by the count of samples accumulated
    always_comb
    begin
        s_next = s_reg;
        s_next.vld = 1'b0;
        s_next.acc = s_reg.acc + 32'(c.sample);
        s_next.cnt = s_reg.cnt + 16'd1;
        if (s_reg.cnt == 16'd0)
            s_next.pick = c.sample;
        if (c.tick)
        begin
            if (c.avg)
                s_next.out = s_reg.cnt == 16'd0 ? c.sample : 16'(s_reg.acc / $signed({16'd0, s_reg.cnt}));
            else
                s_next.out = s_reg.cnt == 16'd0 ? c.sample : s_reg.pick;
            s_next.vld = c.strm_on;
            s_next.acc = 32'sd0;
            s_next.cnt = 16'd0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else if (clk_en)
            s_reg <= s_next;
    end

    assign c.out_data = s_reg.out;
    assign c.out_valid = s_reg.vld;
endmodule

// File: test/scope_trigger_acquisition_properties.sv
// port checker for the capture unit, bound to its top module
`timescale 1ns/100ps
module scope_trigger_acquisition_properties
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic option_installed,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [15:0] mem_addr,
    input wire logic mem_we,
    input wire logic shot_done,
    input wire logic signed [15:0] stream0_data,
    input wire logic stream0_valid,
    input wire logic stream1_valid,
    input wire logic signed [15:0] stream1_data_unused,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    shot_pulse_a: assert property (shot_done |=> !shot_done)
        else $error("shot done held longer than one cycle");
    mem_range_a: assert property (mem_we |-> mem_addr < 16'h1000)
        else $error("capture write beyond memory");
    // writes of one shot land on consecutive words, a wrap aside
    mem_step_a: assert property (mem_we && $past(mem_we) && $past(clk_en) |->
        mem_addr == $past(mem_addr) + 16'h1 || mem_addr == 16'h0)
        else $error("capture address skipped");
    stream_option_a: assert property (!option_installed [*3] |->
        !stream0_valid && !stream1_valid)
        else $error("stream active without option");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    reset_quiet_a: assert property ($rose(rst_n) |-> !irq && !mem_we && !shot_done)
        else $error("outputs busy right after reset");
    spare_zero_a: assert property (stream1_data_unused == 16'sh0)
        else $error("spare stream output not zero");
    freeze_hold_a: assert property (!clk_en |=> $stable(mem_addr) && $stable(stream0_data))
        else $error("state moved while frozen");
endmodule

bind scope_trigger_acquisition scope_trigger_acquisition_properties
    scope_trigger_acquisition_properties_i
(
    .clk, .rst_n, .clk_en, .option_installed, .hreadyout, .hresp, .mem_addr, .mem_we,
    .shot_done, .stream0_data, .stream0_valid, .stream1_valid, .stream1_data_unused, .irq
);

// File: test/stream_host.sv
// host side model: takes stream samples and measures their spacing
`timescale 1ns/100ps
module stream_host
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic valid,
    input wire logic [15:0] data,
    output int gap,
    output int cnt,
    output logic [15:0] last
);
    int run;

    // host never stalls, so the spacing seen is the device's own rate
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run <= 0;
            gap <= 0;
            cnt <= 0;
            last <= 16'h0;
        end
        else if (valid)
        begin
            gap <= run + 1;
            run <= 0;
            cnt <= cnt + 1;
            last <= data;
        end
        else
            run <= run + 1;
    end
endmodule

// File: test/tb_scope_trigger_acquisition.sv
// bench for the capture unit: bus tasks, register, trigger and stream tests
`timescale 1ns/100ps
`include "scope_cfg.svh"
module tb_scope_trigger_acquisition;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic option_installed = 1'b0, trig_in3 = 1'b0, trig_in4 = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, mem_we, shot_done, stream0_valid, stream1_valid, irq;
    logic [15:0] src_bus [0:255];
    logic signed [15:0] capture_sample = 16'shff9c;
    logic signed [15:0] stream0_data;
    logic [15:0] mem_addr, last;
    int n_mismatch = 0, comparisons = 0, gap, cnt, c0;
    int ok[] = '{0, 9, 11, 4, 16, 39, 55, 71, 83, 97, 113, 147, 179, 195, 211};
    int bad[] = '{12, 24, 160, 161, 212, 255};
    int segs[] = '{2, 4, 256};

    always #25 clk = ~clk;

    scope_trigger_acquisition scope_trigger_acquisition_i
    (
        .clk, .rst_n, .clk_en, .haddr_sel(1'b0), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
        .option_installed, .trig_in3, .trig_in4, .src_bus, .capture_sample, .mem_addr,
        .mem_data(), .mem_we, .shot_done, .stream0_data, .stream0_valid,
        .stream1_data(), .stream1_data_unused(), .stream1_valid, .irq
    );

    stream_host stream_host_i
    (
        .clk, .rst_n, .valid(stream0_valid), .data(stream0_data), .gap, .cnt, .last
    );

    // one single word transfer; waits for ready in both phases
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= v;
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(d, exp);
    endtask

    // move the trigger signal, then look at the trigger flag and the irq line
    task automatic step(input logic signed [15:0] v, input logic s, input logic q);
        capture_sample <= v;
        repeat (40) @(posedge clk);
        xfer(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk({31'h0, d[0]}, {31'h0, s});
        chk({31'h0, irq}, {31'h0, q});
        xfer(1'b1, `OFF_IRQ_CLR, 32'h7);
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // a hang ends the run the same way as the tests do
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        for (int i = 0; i < 256; i++)
            src_bus[i] = 16'(i) ^ 16'h5a00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`OFF_RATE, 32'h10);
        rdchk(`OFF_SEG_NUM, 32'h1);
        xfer(1'b0, `OFF_STATUS, 32'h0);
        chk({27'h0, d[4:0]}, 32'h2);
        // extended codes are refused until the option is present
        xfer(1'b1, `OFF_SRC0, 32'h9);
        xfer(1'b1, `OFF_SRC0, 32'h10);
        rdchk(`OFF_SRC0, 32'h9);
        option_installed <= 1'b1;
        foreach (ok[i])
        begin
            xfer(1'b1, `OFF_SRC0, ok[i]);
            rdchk(`OFF_SRC0, ok[i]);
        end
        foreach (bad[i])
        begin
            xfer(1'b1, `OFF_SRC0, bad[i]);
            rdchk(`OFF_SRC0, 32'hd3);
        end
        for (int r = 6; r <= 17; r++)
        begin
            xfer(1'b1, `OFF_RATE, r);
            rdchk(`OFF_RATE, (r > 16) ? 16 : r);
        end
        for (int g = 0; g <= 4; g++)
        begin
            xfer(1'b1, `OFF_GATE_SRC, g);
            rdchk(`OFF_GATE_SRC, (g > 3) ? 3 : g);
        end
        xfer(1'b1, `OFF_CTRL, 32'h1);
        foreach (segs[i])
        begin
            xfer(1'b1, `OFF_SEG_NUM, segs[i]);
            rdchk(`OFF_SEG_SIZE, 4096 / segs[i]);
        end
        xfer(1'b1, `OFF_SEG_NUM, 32'h0);
        xfer(1'b1, `OFF_SEG_NUM, 32'h101);
        rdchk(`OFF_SEG_NUM, 32'h100);
        xfer(1'b1, `OFF_HYST_F, 32'h280);
        rdchk(`OFF_HYST_F, 32'h280);
        xfer(1'b1, `OFF_CTRL, 32'h4);
        rdchk(`OFF_CTRL, 32'h4);
        xfer(1'b1, `OFF_HYST_V, 32'h0);
        xfer(1'b1, `OFF_BOT0, 32'hff00);
        xfer(1'b1, `OFF_TOP0, 32'h0100);
        // short segments keep each shot brief so the trigger rearms quickly
        xfer(1'b1, `OFF_IRQ_EN, 32'h1);
        for (int e = 0; e < 4; e++)
        begin
            xfer(1'b1, `OFF_CTRL, 32'h1 | (e << 7));
            step(16'sh0064, e[0], e[0]);
            step(16'shff9c, e[1], e[1]);
        end
        xfer(1'b1, `OFF_CTRL, 32'h81);
        xfer(1'b1, `OFF_IRQ_EN, 32'h0);
        step(16'sh0064, 1'b1, 1'b0);
        step(16'shff9c, 1'b0, 1'b0);
        xfer(1'b1, `OFF_IRQ_EN, 32'h1);
        xfer(1'b1, `OFF_CTRL, 32'h83);
        for (int g = 0; g < 4; g++)
        begin
            xfer(1'b1, `OFF_GATE_SRC, g);
            trig_in3 <= g[0] ^ g[1];
            trig_in4 <= ~(g[0] ^ g[1]);
            step(16'sh0064, 1'b0, 1'b0);
            step(16'shff9c, 1'b0, 1'b0);
            trig_in3 <= ~(g[0] ^ g[1]);
            trig_in4 <= g[0] ^ g[1];
            step(16'sh0064, 1'b1, 1'b1);
            step(16'shff9c, 1'b0, 1'b0);
        end
        // both channel modes, three rates; constant source keeps data exact
        xfer(1'b1, `OFF_SRC0, 32'h9);
        for (int a = 0; a < 2; a++)
            for (int r = 6; r <= 8; r++)
            begin
                xfer(1'b1, `OFF_RATE, r);
                xfer(1'b1, `OFF_CTRL, 32'h20 | (a << 3));
                // the divider finishes the slow period left from earlier rate settings
                repeat (1100) @(posedge clk);
                chk(gap, 1 << (r - 6));
                chk({16'h0, last}, {16'h0, src_bus[9]});
            end
        clk_en <= 1'b0;
        repeat (8) @(posedge clk);
        clk_en <= 1'b1;
        option_installed <= 1'b0;
        repeat (4) @(posedge clk);
        c0 = cnt;
        repeat (20) @(posedge clk);
        chk(cnt, c0);
        finish_test;
    end
endmodule
